//--- scan_tap_chk.sv
`timescale 1ns/1ps
`include "scan_tap_regs.svh"

module scan_tap_chk
  import scan_tap_pkg::*;
#(
  parameter int TCK_HALF = `HOST_TCK_HALF
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe
);
  tap_state_t st_reg;
  logic [3:0] fall_cnt_reg;
  logic [7:0] run_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // shadow controller, steered by the wire alone
  function automatic tap_state_t nxt(tap_state_t s, logic m);
    case (s)
      TAP_RESET: return m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE, TAP_UPD_DR, TAP_UPD_IR: return m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: return m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR, TAP_SHIFT_DR: return m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: return m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: return m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: return m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_SEL_IR: return m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR, TAP_SHIFT_IR: return m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: return m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: return m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      default: return m ? TAP_UPD_IR : TAP_SHIFT_IR;
    endcase
  endfunction : nxt

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= TAP_RESET;
    end else if ($rose(i_tck)) begin
      st_reg <= nxt(st_reg, i_tms);
    end
  end

  // mclk cycles since the last tck fall
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fall_cnt_reg <= 4'h0;
    end else if ($fell(i_tck)) begin
      fall_cnt_reg <= 4'h1;
    end else if (fall_cnt_reg != 4'hf) begin
      fall_cnt_reg <= fall_cnt_reg + 4'h1;
    end
  end

  // mclk cycles since tck last changed
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_cnt_reg <= 8'h0;
    end else if ($changed(i_tck)) begin
      run_cnt_reg <= 8'h1;
    end else if (run_cnt_reg != 8'hff) begin
      run_cnt_reg <= run_cnt_reg + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  sequence s_fall_shift;
    $fell(i_tck) && (st_reg inside {TAP_SHIFT_IR, TAP_SHIFT_DR});
  endsequence

  sequence s_fall_exit;
    $fell(i_tck) && (st_reg inside {TAP_EXIT1_IR, TAP_EXIT1_DR});
  endsequence

  a_tms_tdi_fall: assert property (
    ($changed(i_tms) || $changed(i_tdi)) |-> !i_tck)
    else $error("tms or tdi moved while tck high");
  a_tck_half_high: assert property (
    $fell(i_tck) |-> run_cnt_reg == TCK_HALF)
    else $error("tck high phase has wrong length");
  a_tdo_after_fall: assert property (
    ($changed(i_tdo_oe) || $changed(i_tdo)) |->
      fall_cnt_reg inside {[1:7]})
    else $error("tdo moved away from a tck fall");
  a_tdo_on_shift: assert property (
    s_fall_shift |-> ##[1:7] i_tdo_oe)
    else $error("tdo not driven in shift");
  a_tdo_off_exit: assert property (
    s_fall_exit |-> ##[1:7] !i_tdo_oe)
    else $error("tdo not released in exit1");
  a_tdo_only_scan: assert property (
    i_tdo_oe |-> st_reg inside {TAP_SHIFT_IR, TAP_SHIFT_DR,
                              TAP_EXIT1_IR, TAP_EXIT1_DR})
    else $error("tdo driven outside a scan");
  a_ir_capture_first: assert property (
    $rose(i_tdo_oe) && st_reg == TAP_SHIFT_IR |-> i_tdo)
    else $error("first instruction bit out not one");
  a_exit_no_drive: assert property (
    st_reg inside {TAP_EXIT1_IR, TAP_EXIT1_DR} |-> !$rose(i_tdo_oe))
    else $error("tdo enabled in exit1");
endmodule : scan_tap_chk

//--- scan_tap_device.sv
// Behaviour
// (RL1) all test logic advances on test clock only
// (RL2) tdi, tms, pins sampled at tck rise
// (RL3) tdo and pin outputs change at fall
// (RL4) controller changes tms at fall, rises next
// (RL5) tms low at rise leaves reset state
// (RL6) ir scan passes idle, selects, capture first
// (RL7) capture-ir loads 10000001 on exiting rise
// (RL8) tdo drives from fall in shift states
// (RL9) ir shifts one bit per rise
// (RL10) controller raises tms on last shift
// (RL11) last ir bit shifts entering exit1-ir
// (RL12) tdo released at fall in exit1
// (RL13) update-ir fall loads instruction; ones bypass
// (RL14) bypass register captures zero at capture-dr
// (RL15) bypass gives one-bit tdi to tdo delay
// (RL16) update-dr fall loads parallel output stage
// (RL17) tms high from select-ir returns reset
// (RL18) other moves follow standard sixteen-state controller
`timescale 1ns/1ps
`include "scan_tap_regs.svh"

module scan_tap_device #(
  parameter int DR_W = `TAP_DR_W
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  scan_tap_if.device link,
  input wire logic [DR_W-1:0] i_pin_data,
  output logic [DR_W-1:0] o_pin_data,
  output logic [`TAP_IR_W-1:0] o_instr,
  output scan_tap_pkg::tap_state_t o_tap_state,
  output logic o_test_reset,
  output logic o_bypass_sel
);
  import scan_tap_pkg::*;

  initial begin
    if (DR_W < 1 || DR_W > 64) begin
      $error("DR_W out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finding

  logic tck_s1_reg;
  logic tck_s2_reg;
  logic tck_d_reg;
  logic tms_s1_reg;
  logic tms_s2_reg;
  logic tdi_s1_reg;
  logic tdi_s2_reg;
  logic [DR_W-1:0] pin_s1_reg, pin_s2_reg;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tck_s1_reg <= 1'b0;
      tck_s2_reg <= 1'b0;
      tck_d_reg <= 1'b0;
      tms_s1_reg <= 1'b1;
      tms_s2_reg <= 1'b1;
      tdi_s1_reg <= 1'b1;
      tdi_s2_reg <= 1'b1;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      tck_s1_reg <= link.tck;
      tck_s2_reg <= tck_s1_reg;
      tck_d_reg <= tck_s2_reg;
      tms_s1_reg <= link.tms;
      tms_s2_reg <= tms_s1_reg;
      tdi_s1_reg <= link.tdi;
      tdi_s2_reg <= tdi_s1_reg;
      pin_s1_reg <= i_pin_data;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // every test-logic step below except the status-output registers is gated by one of these
  assign tck_rise = tck_s2_reg & ~tck_d_reg; // RL1
  assign tck_fall = ~tck_s2_reg & tck_d_reg; // RL1

  ////////////////////////////////////////////////////////////////////////////
  // tap controller

  tap_state_t state_reg;
  tap_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TAP_RESET: begin
        state_next = tms_s2_reg ? TAP_RESET : TAP_IDLE; // RL5
      end
      TAP_IDLE: begin
        state_next = tms_s2_reg ? TAP_SEL_DR : TAP_IDLE; // RL6
      end
      TAP_SEL_DR: begin
        state_next = tms_s2_reg ? TAP_SEL_IR : TAP_CAP_DR; // RL6
      end
      TAP_CAP_DR: begin
        state_next = tms_s2_reg ? TAP_EXIT1_DR : TAP_SHIFT_DR; // RL18
      end
      TAP_SHIFT_DR: begin
        state_next = tms_s2_reg ? TAP_EXIT1_DR : TAP_SHIFT_DR; // RL18
      end
      TAP_EXIT1_DR: begin
        state_next = tms_s2_reg ? TAP_UPD_DR : TAP_PAUSE_DR; // RL18
      end
      TAP_PAUSE_DR: begin
        state_next = tms_s2_reg ? TAP_EXIT2_DR : TAP_PAUSE_DR; // RL18
      end
      TAP_EXIT2_DR: begin
        state_next = tms_s2_reg ? TAP_UPD_DR : TAP_SHIFT_DR; // RL18
      end
      TAP_UPD_DR: begin
        state_next = tms_s2_reg ? TAP_SEL_DR : TAP_IDLE; // RL18
      end
      TAP_SEL_IR: begin
        state_next = tms_s2_reg ? TAP_RESET : TAP_CAP_IR; // RL17
      end
      TAP_CAP_IR: begin
        state_next = tms_s2_reg ? TAP_EXIT1_IR : TAP_SHIFT_IR; // RL6
      end
      TAP_SHIFT_IR: begin
        state_next = tms_s2_reg ? TAP_EXIT1_IR : TAP_SHIFT_IR; // RL11
      end
      TAP_EXIT1_IR: begin
        state_next = tms_s2_reg ? TAP_UPD_IR : TAP_PAUSE_IR; // RL18
      end
      TAP_PAUSE_IR: begin
        state_next = tms_s2_reg ? TAP_EXIT2_IR : TAP_PAUSE_IR; // RL18
      end
      TAP_EXIT2_IR: begin
        state_next = tms_s2_reg ? TAP_UPD_IR : TAP_SHIFT_IR; // RL18
      end
      TAP_UPD_IR: begin
        state_next = tms_s2_reg ? TAP_SEL_DR : TAP_IDLE; // RL18
      end
      default: begin
        state_next = TAP_RESET;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= TAP_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next; // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift stages, advanced on the rising edge

  logic [`TAP_IR_W-1:0] ir_shift_reg;
  logic [DR_W-1:0] dr_shift_reg;
  logic bypass_reg;
  logic [`TAP_IR_W-1:0] instr_reg;
  logic bypass_sel;

  assign bypass_sel = (instr_reg == `TAP_IR_BYPASS); // RL13

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ir_shift_reg <= `TAP_IR_CAPTURE;
    end else if (tck_rise) begin
      if (state_reg == TAP_CAP_IR) begin
        ir_shift_reg <= `TAP_IR_CAPTURE; // RL7
      end else if (state_reg == TAP_SHIFT_IR) begin
        ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[`TAP_IR_W-1:1]}; // RL9
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && bypass_sel) begin
      if (state_reg == TAP_CAP_DR) begin
        bypass_reg <= 1'b0; // RL14
      end else if (state_reg == TAP_SHIFT_DR) begin
        bypass_reg <= tdi_s2_reg; // RL15
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dr_shift_reg <= '0;
    end else if (tck_rise && !bypass_sel) begin
      if (state_reg == TAP_CAP_DR) begin
        dr_shift_reg <= pin_s2_reg; // RL2
      end else if (state_reg == TAP_SHIFT_DR) begin
        dr_shift_reg <= {tdi_s2_reg, dr_shift_reg[DR_W-1:1]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // falling-edge updates: tdo, instruction, parallel outputs

  logic tdo_reg;
  logic tdo_oe_reg;
  logic [DR_W-1:0] pin_out_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      // shift states drive, every other state (exit1 first) releases
      tdo_oe_reg <= (state_reg == TAP_SHIFT_IR) ||
                    (state_reg == TAP_SHIFT_DR); // RL8 RL12 RL3
      if (state_reg == TAP_SHIFT_IR) begin
        tdo_reg <= ir_shift_reg[0]; // RL9
      end else if (bypass_sel) begin
        tdo_reg <= bypass_reg; // RL15
      end else begin
        tdo_reg <= dr_shift_reg[0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      instr_reg <= `TAP_IR_BYPASS;
    end else if (tck_fall) begin
      if (state_reg == TAP_RESET) begin
        instr_reg <= `TAP_IR_BYPASS;
      end else if (state_reg == TAP_UPD_IR) begin
        instr_reg <= ir_shift_reg; // RL13
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_out_reg <= '0;
    end else if (tck_fall && state_reg == TAP_UPD_DR && !bypass_sel) begin
      pin_out_reg <= dr_shift_reg; // RL16 RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs

  logic test_reset_reg;
  logic bypass_sel_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      test_reset_reg <= 1'b1;
      bypass_sel_reg <= 1'b1;
    end else begin
      test_reset_reg <= (state_reg == TAP_RESET);
      bypass_sel_reg <= bypass_sel;
    end
  end

  assign link.tdo = tdo_reg;
  assign link.tdo_oe = tdo_oe_reg;
  assign o_pin_data = pin_out_reg;
  assign o_instr = instr_reg;
  assign o_tap_state = state_reg;
  assign o_test_reset = test_reset_reg;
  assign o_bypass_sel = bypass_sel_reg;

endmodule : scan_tap_device

//--- scan_tap_host.sv
`timescale 1ns/1ps
`include "scan_tap_regs.svh"

module scan_cmd_fifo #(
  parameter int WIDTH = `CMD_W,
  parameter int DEPTH = `CMD_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("fifo depth must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic wr_ready_reg;
  logic empty_reg;
  logic do_wr;
  logic do_rd;

  assign do_wr = i_wr_valid && wr_ready_reg;
  assign do_rd = i_rd_ready && !empty_reg;

  always_comb begin
    count_next = count_reg;
    if (do_wr && !do_rd) begin
      count_next = count_reg + 1'b1;
    end else if (do_rd && !do_wr) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= i_wr_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      wr_ready_reg <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_reg <= do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_reg <= count_next;
      wr_ready_reg <= (count_next != DEPTH[AW:0]);
      empty_reg <= (count_next == '0);
    end
  end

  assign o_wr_ready = wr_ready_reg;
  assign o_rd_valid = !empty_reg;
  assign o_rd_data = mem[rd_ptr_reg];

endmodule : scan_cmd_fifo

////////////////////////////////////////////////////////////////////////////////

module scan_tap_host #(
  parameter int TCK_HALF = `HOST_TCK_HALF
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  scan_tap_if.host link,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [`CMD_W-1:0] i_cmd_data,
  output logic o_rsp_valid,
  output logic [`CMD_DATA_W-1:0] o_rsp_data,
  output logic o_busy
);
  import scan_tap_pkg::*;

  initial begin
    if (TCK_HALF < 8 || TCK_HALF > 65535) begin
      $error("TCK_HALF must cover tdo round trip");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command fifo

  logic fifo_valid;
  logic fifo_pop;
  logic [`CMD_W-1:0] fifo_data;

  scan_cmd_fifo #(.WIDTH(`CMD_W), .DEPTH(`CMD_FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_wr_valid(i_cmd_valid),
    .o_wr_ready(o_cmd_ready),
    .i_wr_data(i_cmd_data),
    .o_rd_valid(fifo_valid),
    .i_rd_ready(fifo_pop),
    .o_rd_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // test clock divider

  logic [15:0] div_reg;
  logic tck_reg;
  logic tick;
  logic fall_tick;
  logic rise_tick;

  assign tick = (div_reg == 16'(TCK_HALF - 1));
  assign fall_tick = tick && tck_reg;
  assign rise_tick = tick && !tck_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_reg <= '0;
      tck_reg <= 1'b0;
    end else begin
      div_reg <= tick ? '0 : div_reg + 1'b1;
      tck_reg <= tick ? !tck_reg : tck_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tdo synchroniser

  logic tdo_s1_reg;
  logic tdo_s2_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tdo_s1_reg <= 1'b1;
      tdo_s2_reg <= 1'b1;
    end else begin
      tdo_s1_reg <= link.tdo_line;
      tdo_s2_reg <= tdo_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: tms/tdi change at fall, tdo taken at rise

  host_phase_t phase_reg;
  logic [5:0] pre_bits_reg;
  logic [2:0] pre_cnt_reg;
  logic [1:0] post_bits_reg;
  logic [1:0] post_cnt_reg;
  logic [`CMD_DATA_W-1:0] data_reg;
  logic [`CMD_LEN_W-1:0] last_reg;
  logic [`CMD_LEN_W-1:0] bit_reg;
  logic [`CMD_LEN_W-1:0] samp_reg;
  logic scan_reg;
  logic sample_reg;
  logic tms_reg;
  logic tdi_reg;
  logic rsp_valid_reg;
  logic [`CMD_DATA_W-1:0] rsp_reg;
  logic busy_reg;
  cmd_op_t op;

  assign op = cmd_op_t'(fifo_data[`CMD_OP_LSB +: `CMD_OP_W]);
  assign fifo_pop = fall_tick && phase_reg == H_IDLE && fifo_valid;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_reg <= H_PRE;
      pre_bits_reg <= `PRE_RESET_BITS; // RL5
      pre_cnt_reg <= `PRE_RESET_LEN;
      post_bits_reg <= `POST_BITS;
      post_cnt_reg <= `POST_LEN;
      data_reg <= '0;
      last_reg <= '0;
      bit_reg <= '0;
      scan_reg <= 1'b0;
      sample_reg <= 1'b0;
      tms_reg <= 1'b1;
      tdi_reg <= 1'b1;
    end else if (fall_tick) begin
      sample_reg <= (phase_reg == H_SHIFT);
      case (phase_reg)
        H_IDLE: begin
          tms_reg <= 1'b0;
          if (fifo_valid && op != OP_NONE) begin
            phase_reg <= H_PRE;
            data_reg <= fifo_data[`CMD_DATA_LSB +: `CMD_DATA_W];
            last_reg <= fifo_data[`CMD_LEN_LSB +: `CMD_LEN_W];
            bit_reg <= '0;
            scan_reg <= (op != OP_RESET);
            post_bits_reg <= `POST_BITS;
            post_cnt_reg <= `POST_LEN;
            case (op)
              OP_IR_SCAN: begin
                pre_bits_reg <= `PRE_IR_BITS; // RL6
                pre_cnt_reg <= `PRE_IR_LEN;
              end
              OP_DR_SCAN: begin
                pre_bits_reg <= `PRE_DR_BITS;
                pre_cnt_reg <= `PRE_DR_LEN;
              end
              default: begin
                pre_bits_reg <= `PRE_RESET_BITS; // RL17
                pre_cnt_reg <= `PRE_RESET_LEN;
              end
            endcase
          end
        end
        H_PRE: begin
          tms_reg <= pre_bits_reg[0]; // RL4
          pre_bits_reg <= pre_bits_reg >> 1;
          pre_cnt_reg <= pre_cnt_reg - 1'b1;
          if (pre_cnt_reg == 3'h1) begin
            phase_reg <= scan_reg ? H_SHIFT : H_IDLE;
          end
        end
        H_SHIFT: begin
          tdi_reg <= data_reg[bit_reg];
          tms_reg <= (bit_reg == last_reg); // RL10
          bit_reg <= bit_reg + 1'b1;
          if (bit_reg == last_reg) begin
            phase_reg <= H_POST;
          end
        end
        H_POST: begin
          tms_reg <= post_bits_reg[0]; // RL4
          post_bits_reg <= post_bits_reg >> 1;
          post_cnt_reg <= post_cnt_reg - 1'b1;
          if (post_cnt_reg == 2'h1) begin
            phase_reg <= H_IDLE;
          end
        end
        default: begin
          phase_reg <= H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      samp_reg <= '0;
      rsp_reg <= '0;
    end else if (fifo_pop) begin
      samp_reg <= '0;
      rsp_reg <= '0;
    end else if (rise_tick && sample_reg) begin
      rsp_reg[samp_reg] <= tdo_s2_reg;
      samp_reg <= samp_reg + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rsp_valid_reg <= 1'b0;
      busy_reg <= 1'b1;
    end else begin
      busy_reg <= (phase_reg != H_IDLE);
      rsp_valid_reg <= fall_tick && phase_reg == H_POST &&
                       post_cnt_reg == 2'h1;
    end
  end

  assign link.tck = tck_reg;
  assign link.tms = tms_reg;
  assign link.tdi = tdi_reg;
  assign o_rsp_valid = rsp_valid_reg;
  assign o_rsp_data = rsp_reg;
  assign o_busy = busy_reg;

endmodule : scan_tap_host

//--- scan_tap_if.sv
`timescale 1ns/1ps

interface scan_tap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // released line reads high through the pull-up
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport device (
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdo_oe
  );

  modport host (
    output tck,
    output tms,
    output tdi,
    input tdo_line
  );
endinterface : scan_tap_if

//--- scan_tap_pkg.sv
package scan_tap_pkg;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'ha,
    TAP_SHIFT_IR = 4'hb,
    TAP_EXIT1_IR = 4'hc,
    TAP_PAUSE_IR = 4'hd,
    TAP_EXIT2_IR = 4'he,
    TAP_UPD_IR = 4'hf
  } tap_state_t;

  typedef enum logic [1:0] {
    OP_RESET = 2'h0,
    OP_IR_SCAN = 2'h1,
    OP_DR_SCAN = 2'h2,
    OP_NONE = 2'h3
  } cmd_op_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_PRE = 2'h1,
    H_SHIFT = 2'h2,
    H_POST = 2'h3
  } host_phase_t;

endpackage : scan_tap_pkg

//--- scan_tap_regs.svh
`ifndef SCAN_TAP_REGS_SVH
`define SCAN_TAP_REGS_SVH

// instruction register
`define TAP_IR_W 8
`define TAP_IR_CAPTURE 8'h81
`define TAP_IR_BYPASS 8'hff

// data register stand-in for the normal-function pins
`define TAP_DR_W 18

// host command word layout: {op, length - 1, data}
`define CMD_DATA_W 18
`define CMD_LEN_W 5
`define CMD_OP_W 2
`define CMD_W 25
`define CMD_DATA_LSB 0
`define CMD_LEN_LSB 18
`define CMD_OP_LSB 23

// host-made test clock
`define MCLK_PERIOD_NS 5
`define HOST_TCK_PERIOD_NS 250
`define HOST_TCK_HALF ((`HOST_TCK_PERIOD_NS) / (2 * (`MCLK_PERIOD_NS)))

// tms patterns, sent lsb first
`define PRE_IR_BITS 6'h03
`define PRE_IR_LEN 3'h4
`define PRE_DR_BITS 6'h01
`define PRE_DR_LEN 3'h3
`define PRE_RESET_BITS 6'h1f
`define PRE_RESET_LEN 3'h6
`define POST_BITS 2'h1
`define POST_LEN 2'h2

// command fifo
`define CMD_FIFO_DEPTH 8

`endif

//--- tb.sv
`timescale 1ns/1ps
`include "scan_tap_regs.svh"

module tb;
  import scan_tap_pkg::*;
  localparam int TCK_HALF = 8;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [`CMD_W-1:0] cmd_data = '0;
  logic [17:0] pin_in = 18'h0;
  logic cmd_ready, rsp_valid, busy, test_reset, bypass_sel;
  logic [17:0] rsp_data, pin_out, r;
  logic [7:0] instr;
  tap_state_t tap_state;
  logic [17:0] rsp_q[$];
  logic full_seen = 1'b0;
  int miscompares = 0;
  int n_compared = 0;

  always #2.5 i_mclk = ~i_mclk;

  scan_tap_if lnk();
  scan_tap_host #(.TCK_HALF(TCK_HALF)) i_scan_tap_host (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .link(lnk.host),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready),
    .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .o_busy(busy));
  scan_tap_device i_scan_tap_device (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .link(lnk.device),
    .i_pin_data(pin_in), .o_pin_data(pin_out), .o_instr(instr),
    .o_tap_state(tap_state), .o_test_reset(test_reset),
    .o_bypass_sel(bypass_sel));
  scan_tap_chk #(.TCK_HALF(TCK_HALF)) i_scan_tap_chk (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_tck(lnk.tck),
    .i_tms(lnk.tms), .i_tdi(lnk.tdi), .i_tdo(lnk.tdo),
    .i_tdo_oe(lnk.tdo_oe));

  always @(negedge i_mclk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (cmd_ready === 1'b0) full_seen = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic timeout(input string what);
    $display("[ERR] %s expected done seen timeout", what);
    miscompares++;
    final_report();
  endtask : timeout

  task automatic send(input cmd_op_t op, input logic [4:0] len,
                      input logic [17:0] d);
    int i;
    @(posedge i_mclk);
    cmd_valid <= 1'b1;
    cmd_data <= {op, len, d};
    for (i = 0; i < 5000; i++) begin
      @(negedge i_mclk);
      if (cmd_ready === 1'b1) break;
    end
    if (i == 5000) timeout("cmd_ready");
    @(posedge i_mclk);
    cmd_valid <= 1'b0;
  endtask : send

  task automatic get_rsp(output logic [17:0] d);
    int i;
    for (i = 0; i < 20000; i++) begin
      @(negedge i_mclk);
      if (rsp_q.size() > 0) break;
    end
    if (i == 20000) timeout("rsp_valid");
    d = rsp_q.pop_front();
  endtask : get_rsp

  task automatic scan(input cmd_op_t op, input logic [4:0] len,
                      input logic [17:0] d, output logic [17:0] q);
    send(op, len, d);
    get_rsp(q);
    // let the update fall reach the device outputs
    repeat (8) @(negedge i_mclk);
  endtask : scan

  task automatic wait_state(input tap_state_t s);
    int i;
    for (i = 0; i < 5000; i++) begin
      @(negedge i_mclk);
      if (tap_state === s) break;
    end
    if (i == 5000) timeout("tap_state");
  endtask : wait_state

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_mclk);
    check("test_reset", test_reset, 1'b1);
    check("instr", instr, 8'hff);
    check("tdo_oe", lnk.tdo_oe, 1'b0);
    i_reset_n <= 1'b1;
    pin_in <= 18'h2d3c5;
    wait_state(TAP_IDLE);
    check("tdo_line", lnk.tdo_line, 1'b1);
    $display("test reset done");
    scan(OP_IR_SCAN, 5'h07, 18'h00012, r);
    check("ir out", r[7:0], 8'h81);
    check("instr", instr, 8'h12);
    check("bypass_sel", bypass_sel, 1'b0);
    $display("test ir scan done");
    scan(OP_DR_SCAN, 5'h11, 18'h1a5e7, r);
    check("dr out", r, 18'h2d3c5);
    check("pins", pin_out, 18'h1a5e7);
    $display("test dr scan done");
    scan(OP_IR_SCAN, 5'h07, 18'h000ff, r);
    check("ir out", r[7:0], 8'h81);
    check("bypass_sel", bypass_sel, 1'b1);
    scan(OP_DR_SCAN, 5'h02, 18'h00005, r);
    check("bypass 3", r[2:0], 3'h2);
    scan(OP_DR_SCAN, 5'h07, 18'h000c5, r);
    check("bypass 8", r[7:0], 8'h8a);
    check("pins kept", pin_out, 18'h1a5e7);
    $display("test bypass done");
    for (int k = 0; k < 11; k++) begin
      send(k == 5 ? OP_NONE : OP_DR_SCAN, 5'h00, 18'h00001);
    end
    check("fifo full", full_seen, 1'b1);
    for (int k = 0; k < 10; k++) begin
      get_rsp(r);
      check("bypass 1", r[0], 1'b0);
    end
    repeat (400) @(posedge i_mclk);
    check("extra rsp", rsp_q.size(), 32'h0);
    $display("test fifo burst done");
    scan(OP_IR_SCAN, 5'h07, 18'h00012, r);
    check("instr", instr, 8'h12);
    send(OP_RESET, 5'h00, 18'h0);
    wait_state(TAP_RESET);
    @(negedge i_mclk);
    @(negedge i_mclk);
    check("test_reset", test_reset, 1'b1);
    check("busy", busy, 1'b1);
    wait_state(TAP_IDLE);
    check("instr", instr, 8'hff);
    check("busy", busy, 1'b0);
    $display("test reset op done");
    final_report();
  end
endmodule : tb
